/* File: src/crf_pkg.sv */
// package: register indices, status bit layout, constants and carrier structs
package crf_pkg;

    // ---------------
    // register file geometry
    // ---------------
    localparam int unsigned NUM_REGS    = 16;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned IDX_W       = 4;

    // dedicated register indices
    localparam logic [3:0] IDX_PROGRAM_COUNTER = 4'h0;
    localparam logic [3:0] IDX_STACK_POINTER   = 4'h1;
    localparam logic [3:0] IDX_STATUS_FLAGS    = 4'h2;
    localparam logic [3:0] IDX_CONST_B         = 4'h3;

    // ---------------
    // status flag bit positions
    // ---------------
    localparam int unsigned SF_CARRY      = 0;
    localparam int unsigned SF_ZERO       = 1;
    localparam int unsigned SF_NEGATIVE   = 2;
    localparam int unsigned SF_IRQ_EN     = 3;
    localparam int unsigned SF_CORE_HALT  = 4;
    localparam int unsigned SF_XTAL_OFF   = 5;
    localparam int unsigned SF_BIAS_OFF   = 6;
    localparam int unsigned SF_SUBCLK_OFF = 7;
    localparam int unsigned SF_OVERFLOW   = 8;
    localparam logic [15:0] SF_IMPL_MASK  = 16'h01FF;

    // sign bit positions for word and byte results
    localparam int unsigned WORD_MSB = 15;
    localparam int unsigned BYTE_MSB = 7;

    // ---------------
    // reset values and constants
    // ---------------
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [15:0] LOW_BYTE_MSK = 16'h00FF;
    localparam logic [15:0] EVEN_MASK    = 16'hFFFE;
    localparam logic [15:0] STACK_STEP   = 16'h0002;

    // source mode codes
    localparam logic [1:0] SM_REGISTER = 2'b00;
    localparam logic [1:0] SM_INDEXED  = 2'b01;
    localparam logic [1:0] SM_INDIRECT = 2'b10;
    localparam logic [1:0] SM_AUTOINC  = 2'b11;

    // generated constants
    localparam logic [15:0] CONST_ZERO = 16'h0000;
    localparam logic [15:0] CONST_ONE  = 16'h0001;
    localparam logic [15:0] CONST_TWO  = 16'h0002;
    localparam logic [15:0] CONST_FOUR = 16'h0004;
    localparam logic [15:0] CONST_EIGHT = 16'h0008;
    localparam logic [15:0] CONST_ALL1 = 16'hFFFF;

    // ---------------
    // APB register map (byte addresses)
    // ---------------
    localparam logic [7:0] APB_REG_BASE  = 8'h00; // 0x00..0x3C: registers 0..15
    localparam logic [7:0] APB_CTRL      = 8'h40; // bit0 halt-debug freeze
    localparam logic [7:0] APB_CLKSTAT   = 8'h44; // low power control outputs
    localparam logic [7:0] APB_CLKUSE    = 8'h48; // oscillator usage inputs
    localparam logic [31:0] APB_ZERO     = 32'h0000_0000;

    // ---------------
    // carrier structs
    // ---------------
    // source operand read request from the decoder
    typedef struct packed {
        logic [3:0] idx;
        logic [1:0] mode;
        logic       byte_op;
    } crf_src_req_s;

    // destination write from the datapath
    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        logic        byte_op;
        logic [15:0] data;
    } crf_wr_s;

    // flag update from the ALU
    typedef struct packed {
        logic        en;
        logic        byte_op;
        logic        is_sub;   // subtract, subtract with carry, compare
        logic        arith;    // add/sub class: overflow is computed
        logic [15:0] op_a;     // source operand
        logic [15:0] op_b;     // destination operand
        logic [15:0] result;
        logic        carry;
    } crf_flag_upd_s;

    // stack and program counter control
    typedef struct packed {
        logic        push;     // predecrement
        logic        pop;      // postincrement
        logic        pop_sp;   // pop into stack pointer itself
        logic [15:0] pop_data;
        logic        pc_adv;
        logic [1:0]  pc_words; // 1, 2 or 3 words
        logic        irq_entry;
    } crf_seq_s;

    // low power control outputs
    typedef struct packed {
        logic core_halt;
        logic sub_clock_off;
        logic dco_bias_off;
        logic crystal_off;
        logic irq_enable;
    } crf_power_s;

endpackage

/* File: src/crf_core.sv */
// register file: program counter, stack pointer, status flags, constants
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns

// Contract
// - sixteen 16-bit registers, four dedicated
// - program counter advances by two, four, six
// - program counter always even address
// - program counter write causes branch
// - stack pointer predecrement push, postincrement pop
// - stack pointer even, software initialised
// - pop into stack pointer loads stored value
// - status flags only register mode word
// - add overflow from operand and result signs
// - subtract overflow from operand and result signs
// - sub clock off bit stops subsystem clock
// - bias off stops generator unless used
// - crystal off stops crystal unless used
// - core halt bit stops execution
// - interrupt enable gates maskable interrupts
// - negative flag from bit 15 or 7
// - zero flag set on zero result
// - carry flag follows operation carry
// - register 2 modes give 0, 4, 8
// - register 3 modes give 0, 1, 2, all-ones
// - constants need no extra fetch
// - constant registers are source only
// - byte write clears upper byte
// - interrupt entry clears halt, subclock, crystal bits
module crf_core
    import crf_pkg::*;
(
    input  wire logic          core_clk,        // core clock
    input  wire logic          rst_b,           // async reset, active low
    // apb slave
    input  wire logic          psel,            // select
    input  wire logic          penable,         // access phase
    input  wire logic          pwrite,          // write direction
    input  wire logic [7:0]    paddr,           // byte address
    input  wire logic [31:0]   pwdata,          // write data
    output logic               pready,          // ready
    output logic [31:0]        prdata,          // read data
    output logic               pslverr,         // error on unmapped address
    // datapath ports
    input  wire crf_src_req_s  src_req,         // source read request
    output logic [15:0]        src_data,        // source operand
    input  wire logic [3:0]    dst_rd_idx,      // destination read index
    output logic [15:0]        dst_data,        // destination operand
    input  wire crf_wr_s       wr,              // destination write
    input  wire crf_flag_upd_s flag_upd,        // flag update
    input  wire crf_seq_s      seq,             // stack and counter control
    input  wire logic          irq_pending,     // maskable interrupt request
    input  wire logic          dco_in_use,      // oscillator sources main/sub clock
    input  wire logic          lfxt_in_use,     // crystal sources main/sub clock
    output logic [15:0]        program_counter, // fetch address
    output logic [15:0]        stack_pointer,   // stack pointer
    output logic [15:0]        status_flags,    // status word
    output logic               branch_taken,    // pulse on counter write
    output logic               irq_accept,      // maskable interrupt allowed
    output crf_power_s         power            // low power controls
);

    // ---------------
    // reset synchroniser
    // ---------------
    logic rst_meta_q;   // first stage
    logic rst_sync_q;   // released reset, active high when run
    logic rst_n;        // internal active-low reset

    // two flops release the reset on the clock
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // ---------------
    // storage
    // ---------------
    // sixteen word storage
    logic [15:0] regs_q [NUM_REGS];   // index 0..15, 3 unused as storage
    logic        halt_freeze_q;       // apb control: freeze datapath writes
    logic        branch_q;            // registered branch pulse

    // apb decode helpers
    logic        apb_wr;              // write takes effect
    logic        apb_rd;              // read access phase
    logic        apb_reg_hit;         // address in register window
    logic [3:0]  apb_idx;             // register index from address
    logic        core_wr_en;          // datapath write allowed

    assign apb_wr      = psel && penable && pwrite;
    assign apb_rd      = psel && penable && !pwrite;
    assign apb_reg_hit = (paddr < APB_CTRL) && (paddr[1:0] == 2'b00);
    assign apb_idx     = paddr[5:2];
    assign core_wr_en  = wr.en && !halt_freeze_q;

    // ---------------
    // functions
    // ---------------
    // sign bit of a result at byte or word width
    function automatic logic sign_of(input logic [15:0] v, input logic byte_op);
        sign_of = byte_op ? v[BYTE_MSB] : v[WORD_MSB];
    endfunction

    // stored value of a write: byte writes clear the upper byte
    function automatic logic [15:0] width_fit(input logic [15:0] v, input logic byte_op);
        width_fit = byte_op ? (v & LOW_BYTE_MSK) : v;
    endfunction

    // ---------------
    // general working registers 4..15
    // ---------------
    genvar gi;
    generate
        for (gi = 4; gi < NUM_REGS; gi++)
        begin : g_work
            // datapath write or apb write
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    regs_q[gi] <= RESET_WORD;
                else if (core_wr_en && wr.idx == IDX_W'(gi))
                    regs_q[gi] <= width_fit(wr.data, wr.byte_op);
                else if (apb_wr && apb_reg_hit && apb_idx == IDX_W'(gi))
                    regs_q[gi] <= pwdata[15:0];
            end
        end
    endgenerate

    // ---------------
    // program counter
    // ---------------
    logic [15:0] pc_step;   // instruction length in bytes

    assign pc_step = {13'h0000, seq.pc_words, 1'b0};

    // counter: write branches, else advance
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regs_q[IDX_PROGRAM_COUNTER] <= RESET_WORD;
            branch_q                    <= 1'b0;
        end
        else
        begin
            branch_q <= 1'b0;
            if (core_wr_en && wr.idx == IDX_PROGRAM_COUNTER)
            begin
                regs_q[IDX_PROGRAM_COUNTER] <= width_fit(wr.data, wr.byte_op) & EVEN_MASK;
                branch_q                    <= 1'b1;
            end
            else if (apb_wr && apb_reg_hit && apb_idx == IDX_PROGRAM_COUNTER)
            begin
                regs_q[IDX_PROGRAM_COUNTER] <= pwdata[15:0] & EVEN_MASK;
                branch_q                    <= 1'b1;
            end
            else if (seq.pc_adv && !power.core_halt)
                regs_q[IDX_PROGRAM_COUNTER] <= (regs_q[IDX_PROGRAM_COUNTER] + pc_step)
                                               & EVEN_MASK;
        end
    end

    // ---------------
    // stack pointer
    // ---------------
    // push predecrements, pop postincrements, writes load
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            regs_q[IDX_STACK_POINTER] <= RESET_WORD;
        else if (seq.pop_sp)
            regs_q[IDX_STACK_POINTER] <= seq.pop_data & EVEN_MASK;
        else if (core_wr_en && wr.idx == IDX_STACK_POINTER)
            regs_q[IDX_STACK_POINTER] <= width_fit(wr.data, wr.byte_op) & EVEN_MASK;
        else if (apb_wr && apb_reg_hit && apb_idx == IDX_STACK_POINTER)
            regs_q[IDX_STACK_POINTER] <= pwdata[15:0] & EVEN_MASK;
        else if (seq.push)
            regs_q[IDX_STACK_POINTER] <= (regs_q[IDX_STACK_POINTER] - STACK_STEP) & EVEN_MASK;
        else if (seq.pop)
            regs_q[IDX_STACK_POINTER] <= (regs_q[IDX_STACK_POINTER] + STACK_STEP) & EVEN_MASK;
    end

    // ---------------
    // status flags
    // ---------------
    logic sa;        // sign of source operand
    logic sb;        // sign of destination operand
    logic sres;      // sign of result
    logic ovf;       // computed overflow
    logic res_zero;  // result is zero at its width

    assign sa = sign_of(flag_upd.op_a, flag_upd.byte_op);
    assign sb = sign_of(flag_upd.op_b, flag_upd.byte_op);
    assign sres = sign_of(flag_upd.result, flag_upd.byte_op);
    assign res_zero = flag_upd.byte_op ? (flag_upd.result[BYTE_MSB:0] == 8'h00)
                                       : (flag_upd.result == RESET_WORD);

    // overflow by operation class
    always_comb
    begin
        if (flag_upd.is_sub)
            ovf = (sb != sa) && (sres != sb);
        else
            ovf = (sa == sb) && (sres != sa);
    end

    // status register: writes, alu update, interrupt entry
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            regs_q[IDX_STATUS_FLAGS] <= RESET_WORD;
        else if (core_wr_en && wr.idx == IDX_STATUS_FLAGS && !wr.byte_op)
            regs_q[IDX_STATUS_FLAGS] <= wr.data & SF_IMPL_MASK;
        else if (apb_wr && apb_reg_hit && apb_idx == IDX_STATUS_FLAGS)
            regs_q[IDX_STATUS_FLAGS] <= pwdata[15:0] & SF_IMPL_MASK;
        else
        begin
            // wake and alu flags touch disjoint bits: both apply
            if (seq.irq_entry)
            begin
                regs_q[IDX_STATUS_FLAGS][SF_CORE_HALT]  <= 1'b0;
                regs_q[IDX_STATUS_FLAGS][SF_SUBCLK_OFF] <= 1'b0;
                regs_q[IDX_STATUS_FLAGS][SF_XTAL_OFF]   <= 1'b0;
            end
            if (flag_upd.en)
            begin
                regs_q[IDX_STATUS_FLAGS][SF_CARRY]    <= flag_upd.carry;
                regs_q[IDX_STATUS_FLAGS][SF_ZERO]     <= res_zero;
                regs_q[IDX_STATUS_FLAGS][SF_NEGATIVE] <= sres;
                regs_q[IDX_STATUS_FLAGS][SF_OVERFLOW] <= flag_upd.arith & ovf;
            end
        end
    end

    // register 3 holds no state
    // source only constant
    assign regs_q[IDX_CONST_B] = RESET_WORD;

    // ---------------
    // source and destination read
    // ---------------
    // source mux with constant generation, same cycle, no fetch
    always_comb
    begin
        src_data = regs_q[src_req.idx];
        if (src_req.idx == IDX_STATUS_FLAGS)
        begin
            unique case (src_req.mode)
                SM_REGISTER: src_data = regs_q[IDX_STATUS_FLAGS];
                SM_INDEXED:  src_data = CONST_ZERO;
                SM_INDIRECT: src_data = CONST_FOUR;
                SM_AUTOINC:  src_data = CONST_EIGHT;
            endcase
        end
        else if (src_req.idx == IDX_CONST_B)
        begin
            unique case (src_req.mode)
                SM_REGISTER: src_data = CONST_ZERO;
                SM_INDEXED:  src_data = CONST_ONE;
                SM_INDIRECT: src_data = CONST_TWO;
                SM_AUTOINC:  src_data = CONST_ALL1;
            endcase
        end
    end

    assign dst_data = regs_q[dst_rd_idx];

    // ---------------
    // low power and interrupt outputs
    // ---------------
    // halt stops core
    assign power.core_halt     = regs_q[IDX_STATUS_FLAGS][SF_CORE_HALT];
    assign power.sub_clock_off = regs_q[IDX_STATUS_FLAGS][SF_SUBCLK_OFF];
    assign power.dco_bias_off  = regs_q[IDX_STATUS_FLAGS][SF_BIAS_OFF] && !dco_in_use;
    assign power.crystal_off   = regs_q[IDX_STATUS_FLAGS][SF_XTAL_OFF] && !lfxt_in_use;
    assign power.irq_enable    = regs_q[IDX_STATUS_FLAGS][SF_IRQ_EN];
    assign irq_accept          = irq_pending && regs_q[IDX_STATUS_FLAGS][SF_IRQ_EN];

    assign program_counter = regs_q[IDX_PROGRAM_COUNTER];
    assign stack_pointer   = regs_q[IDX_STACK_POINTER];
    assign status_flags    = regs_q[IDX_STATUS_FLAGS];
    assign branch_taken    = branch_q;

    // ---------------
    // apb slave
    // ---------------
    // debug freeze control
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            halt_freeze_q <= 1'b0;
        else if (apb_wr && paddr == APB_CTRL)
            halt_freeze_q <= pwdata[0];
    end

    // zero wait states; read data combinational from register state and the oscillator usage inputs
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(apb_reg_hit || paddr == APB_CTRL
                     || paddr == APB_CLKSTAT || paddr == APB_CLKUSE);

    // read mux
    always_comb
    begin
        prdata = APB_ZERO;
        if (apb_rd)
        begin
            if (apb_reg_hit)
                prdata = {16'h0000, regs_q[apb_idx]};
            else if (paddr == APB_CTRL)
                prdata = {31'h0000_0000, halt_freeze_q};
            else if (paddr == APB_CLKSTAT)
                prdata = {27'h000_0000, power};
            else if (paddr == APB_CLKUSE)
                prdata = {30'h0000_0000, lfxt_in_use, dco_in_use};
        end
    end

endmodule

/* File: sim/crf_core_chk.sv */
// port checker for the register file, bound into the core
`timescale 1ns/1ns
module crf_core_chk
    import crf_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          rst_b,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire crf_src_req_s  src_req,
    input wire logic [15:0]   src_data,
    input wire logic [3:0]    dst_rd_idx,
    input wire logic [15:0]   dst_data,
    input wire crf_wr_s       wr,
    input wire crf_flag_upd_s flag_upd,
    input wire crf_seq_s      seq,
    input wire logic          irq_pending,
    input wire logic [15:0]   program_counter,
    input wire logic [15:0]   stack_pointer,
    input wire logic [15:0]   status_flags,
    input wire logic          branch_taken,
    input wire logic          irq_accept,
    input wire crf_power_s    power
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ---------------
    // helper terms
    // ---------------
    logic       apbw; // bus write taken this cycle
    logic [2:0] nzc;  // expected negative, zero, carry
    assign apbw = psel && penable && pwrite;
    assign nzc = {flag_upd.byte_op ? flag_upd.result[7] : flag_upd.result[15],
                  flag_upd.byte_op ? (flag_upd.result[7:0] == 8'h00)
                                   : (flag_upd.result == 16'h0000), flag_upd.carry};
    // plain advance, nothing else touching the counter
    sequence adv_s;
        seq.pc_adv && !wr.en && !apbw && !status_flags[SF_CORE_HALT];
    endsequence
    // byte write to a working register that is being watched
    sequence bw_s;
        wr.en && wr.byte_op && wr.idx >= 4'h4 && dst_rd_idx == wr.idx && !apbw;
    endsequence
    // ---------------
    // assertions
    // ---------------
    chk_pc_even: assert property (
        program_counter[0] == 1'b0) else $error("counter odd");
    chk_sp_even: assert property (
        stack_pointer[0] == 1'b0) else $error("stack pointer odd");
    chk_pc_step: assert property (
        adv_s |=> program_counter == $past(program_counter) + {13'h0, $past(seq.pc_words), 1'b0})
        else $error("counter step wrong");
    chk_branch_pulse: assert property (
        wr.en && wr.idx == 4'h0 |=> branch_taken) else $error("no branch pulse");
    chk_const_b: assert property (
        src_req.idx == 4'h3 && !src_req.byte_op |-> src_data ==
        ((src_req.mode == 2'b11) ? 16'hFFFF : {14'h0, src_req.mode})) else $error("const b");
    chk_const_a: assert property (
        src_req.idx == 4'h2 && src_req.mode != 2'b00 && !src_req.byte_op |-> src_data ==
        ((src_req.mode == 2'b01) ? 16'h0000 : (src_req.mode == 2'b10) ? 16'h0004 : 16'h0008))
        else $error("const a");
    chk_irq_gate: assert property (
        irq_accept == (irq_pending && status_flags[SF_IRQ_EN])) else $error("irq gate");
    chk_halt_out: assert property (
        power.core_halt == status_flags[SF_CORE_HALT] && power.sub_clock_off ==
        status_flags[SF_SUBCLK_OFF]) else $error("halt outputs");
    chk_byte_clear: assert property (
        bw_s ##1 $stable(dst_rd_idx) |-> dst_data[15:8] == 8'h00) else $error("upper byte");
    chk_flag_nzc: assert property (
        flag_upd.en && !(wr.en && wr.idx == 4'h2) && !apbw && !seq.irq_entry
        |=> status_flags[2:0] == $past(nzc)) else $error("flags wrong");
endmodule
bind crf_core crf_core_chk i_crf_core_chk (.core_clk, .rst_b, .psel, .penable, .pwrite,
    .src_req, .src_data, .dst_rd_idx, .dst_data, .wr, .flag_upd, .seq, .irq_pending,
    .program_counter, .stack_pointer, .status_flags, .branch_taken, .irq_accept, .power);

/* File: sim/crf_alu_model.sv */
// behavioural arithmetic unit feeding flag updates to the register file
`timescale 1ns/1ns
module crf_alu_model
    import crf_pkg::*;
(
    input  wire logic        fen,
    input  wire logic [15:0] op_a,
    input  wire logic [15:0] op_b,
    input  wire logic        is_sub,
    input  wire logic        byte_op,
    output crf_flag_upd_s    flag_upd
);
    logic [16:0] ws; // word sum with carry out
    logic [8:0]  bs; // byte sum with carry out
    // subtract is dst plus inverted src plus one: carry means no borrow
    always_comb
    begin
        ws = is_sub ? {1'b0, op_b} + {1'b0, ~op_a} + 17'h1 : {1'b0, op_b} + {1'b0, op_a};
        bs = is_sub ? {1'b0, op_b[7:0]} + {1'b0, ~op_a[7:0]} + 9'h1
                    : {1'b0, op_b[7:0]} + {1'b0, op_a[7:0]};
        flag_upd = {fen, byte_op, is_sub, 1'b1, op_a, op_b,
                    byte_op ? {8'h00, bs[7:0]} : ws[15:0], byte_op ? bs[8] : ws[16]};
    end
endmodule

/* File: sim/crf_core_bench.sv */
// self-checking bench for the register file
`timescale 1ns/1ns
module crf_core_bench;
    import crf_pkg::*;
    logic          core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0000_0000, prdata, rd;
    logic          pready, pslverr, err, branch_taken, irq_accept;
    logic          irq_pending = 1'b0, dco_in_use = 1'b0, lfxt_in_use = 1'b0;
    logic          fen = 1'b0, is_sub = 1'b0, byte_op = 1'b0;
    logic [15:0]   op_a = 16'h0000, op_b = 16'h0000, src_data, dst_data, pcv, spv, sf;
    logic [3:0]    dst_rd_idx = 4'h0;
    crf_src_req_s  src_req = '0;
    crf_wr_s       wr = '0;
    crf_seq_s      seq = '0;
    crf_flag_upd_s fu;
    crf_power_s    power;
    int            mismatches = 0, checks_done = 0, cyc = 0;
    crf_core i_crf_core (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .src_req, .src_data, .dst_rd_idx, .dst_data, .wr,
        .flag_upd(fu), .seq, .irq_pending, .dco_in_use, .lfxt_in_use, .program_counter(pcv),
        .stack_pointer(spv), .status_flags(sf), .branch_taken, .irq_accept, .power);
    crf_alu_model i_crf_alu_model (.fen, .op_a, .op_b, .is_sub, .byte_op, .flag_upd(fu));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    // ---------------
    // shared tasks
    // ---------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // one bus transfer, held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk) penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // let the edge take the request, drop it, look at mid cycle
    task automatic settle;
        @(posedge core_clk) wr <= '0;
        seq <= '0;
        fen <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ---------------
    // scenarios
    // ---------------
    task automatic t_pc_map;
        apb(1'b1, 8'h80, 32'h0000_FFFF);
        cmp({31'h0, err}, 32'h1);
        apb(1'b1, 8'h00, 32'h0000_1235);
        apb(1'b0, 8'h00, 32'h0);
        cmp(rd, 32'h0000_1234);
        for (int w = 1; w <= 3; w++)
        begin
            @(posedge core_clk) seq.pc_adv <= 1'b1;
            seq.pc_words <= 2'(w);
            settle;
        end
        cmp({16'h0, pcv}, 32'h0000_1240);
        @(posedge core_clk) wr <= '{1'b1, 4'h0, 1'b0, 16'h4001};
        settle;
        cmp({15'h0, branch_taken, pcv}, 32'h0001_4000);
        $display("t_pc_map done");
    endtask
    task automatic t_stack;
        apb(1'b1, 8'h04, 32'h0000_0200);
        @(posedge core_clk) seq.push <= 1'b1;
        settle;
        cmp({16'h0, spv}, 32'h0000_01FE);
        @(posedge core_clk) seq.pop <= 1'b1;
        settle;
        cmp({16'h0, spv}, 32'h0000_0200);
        @(posedge core_clk) seq <= '{1'b0, 1'b1, 1'b1, 16'h0301, 1'b0, 2'b00, 1'b0};
        settle;
        cmp({16'h0, spv}, 32'h0000_0300);
        $display("t_stack done");
    endtask
    task automatic t_operand;
        logic [15:0] gb [8] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF,
            16'h0000, 16'h0000, 16'h0004, 16'h0008};
        @(posedge core_clk) wr <= '{1'b1, 4'h3, 1'b0, 16'h1234};
        settle;
        for (int m = 0; m < 8; m++)
        begin
            @(posedge core_clk) src_req <= '{(m < 4) ? 4'h3 : 4'h2, 2'(m), 1'b0};
            @(negedge core_clk) cmp({16'h0, src_data}, {16'h0, gb[m]});
        end
        @(posedge core_clk) wr <= '{1'b1, 4'h5, 1'b1, 16'hABCD};
        dst_rd_idx <= 4'h5;
        settle;
        cmp({16'h0, dst_data}, 32'h0000_00CD);
        apb(1'b1, 8'h40, 32'h0000_0001);
        @(posedge core_clk) wr <= '{1'b1, 4'h5, 1'b0, 16'h5555};
        settle;
        cmp({16'h0, dst_data}, 32'h0000_00CD);
        apb(1'b1, 8'h40, 32'h0000_0000);
        $display("t_operand done");
    endtask
    task automatic t_flags;
        logic [49:0] tv [7] = '{{2'b00, 16'h0001, 16'h7FFF, 16'h0104},
            {2'b00, 16'h0001, 16'hFFFF, 16'h0003}, {2'b01, 16'h0080, 16'h0080, 16'h0103},
            {2'b10, 16'h0001, 16'h8000, 16'h0101}, {2'b10, 16'h0005, 16'h0005, 16'h0003},
            {2'b11, 16'h0002, 16'h0001, 16'h0004}, {2'b10, 16'h8000, 16'h0001, 16'h0104}};
        for (int k = 0; k < 7; k++)
        begin
            @(posedge core_clk) {is_sub, byte_op, op_a, op_b} <= tv[k][49:16];
            fen <= 1'b1;
            settle;
            cmp({16'h0, sf & 16'h0107}, {16'h0, tv[k][15:0]});
        end
        $display("t_flags done");
    endtask
    task automatic t_power;
        apb(1'b1, 8'h08, 32'h0000_00F8);
        @(posedge core_clk) dco_in_use <= 1'b1;
        @(negedge core_clk) cmp({27'h0, power}, 32'h0000_001B);
        @(posedge core_clk) {dco_in_use, lfxt_in_use, irq_pending} <= 3'b011;
        @(negedge core_clk) cmp({26'h0, irq_accept, power}, 32'h0000_003D);
        @(posedge core_clk) wr <= '{1'b1, 4'h2, 1'b1, 16'h00FF};
        settle;
        @(posedge core_clk) seq.irq_entry <= 1'b1;
        settle;
        cmp({16'h0, sf}, 32'h0000_0048);
        apb(1'b0, 8'h44, 32'h0);
        cmp(rd, 32'h0000_0005);
        apb(1'b0, 8'h48, 32'h0);
        cmp(rd, 32'h0000_0002);
        $display("t_power done");
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge core_clk);
        t_pc_map();
        t_stack();
        t_operand();
        t_flags();
        t_power();
        tally_and_finish();
    end
    // watchdog on total run length
    initial
    begin
        wait (cyc == 2000);
        mismatches++;
        tally_and_finish();
    end
endmodule
